// [design/ssp_params.svh]
/*
  Constants of the synchronous serial port in SPI mode: register offsets,
  field positions, mode codes, reset values and bit-rate divider limits.
  Assumes a 25 MHz system clock and an APB slave with byte addresses.
*/
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// ==========================================================
// Register offsets
`define SSP_OFS_STATUS 8'h00
`define SSP_OFS_CTRL1 8'h04
`define SSP_OFS_CTRL3 8'h08
`define SSP_OFS_DATA 8'h0C
`define SSP_OFS_BAUD 8'h10
`define SSP_OFS_FLAG 8'h14

// ==========================================================
// Field positions
`define SSP_STAT_SMP 7
`define SSP_STAT_CKE 6
`define SSP_STAT_BF 0
`define SSP_C1_WRITE_COLLISION_FLAG 7
`define SSP_C1_OVFL 6
`define SSP_C1_EN 5
`define SSP_C1_CKP 4
`define SSP_C1_MODE_HI 3
`define SSP_C3_BOEN 4
`define SSP_FLAG_IRQ 0

// ==========================================================
// Mode codes, divider limits, counts and reset values
`define SSP_MODE_DIV4 4'h0
`define SSP_MODE_DIV16 4'h1
`define SSP_MODE_DIV64 4'h2
`define SSP_MODE_TMR 4'h3
`define SSP_MODE_SLV_SS 4'h4
`define SSP_MODE_SLV_NOSS 4'h5
`define SSP_MODE_BAUD 4'hA
`define SSP_LIM_DIV4 9'h001
`define SSP_LIM_DIV16 9'h007
`define SSP_LIM_DIV64 9'h01F
`define SSP_LAST_BIT 3'h7
`define SSP_LAST_EDGE 4'hF
`define SSP_RST_BYTE 8'h00
`define SSP_RST_WORD 32'h0000_0000

`endif

// [design/ssp_pkg.sv]
/*
  Types of the synchronous serial port.
  Assumes the constants header is included where numbers are needed.
*/
package ssp_pkg;
  typedef logic [7:0] ssp_byte_t;
  typedef logic [3:0] ssp_mode_t;
  typedef enum logic {SSP_M_IDLE, SSP_M_RUN} ssp_mstate_e;
endpackage : ssp_pkg

// [design/ssp_baud_gen.sv]
/*
  Half-period tick generator for the master serial clock.
  Assumes run_in is held high only while a master transfer is running.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ssp_params.svh"
module ssp_baud_gen (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire ssp_pkg::ssp_mode_t mode_in,
  input wire ssp_pkg::ssp_byte_t reload_in,
  input wire logic timer_tick_in,
  output logic tick_out
);
  logic [8:0] count;

  // Half period minus one, in system clocks
  function automatic logic [8:0] half_limit(input ssp_pkg::ssp_mode_t m,
                                            input ssp_pkg::ssp_byte_t r);
    case (m)
      `SSP_MODE_DIV16: half_limit = `SSP_LIM_DIV16;
      `SSP_MODE_DIV64: half_limit = `SSP_LIM_DIV64;
      `SSP_MODE_BAUD: half_limit = {r, 1'b1}; // 2*(reload+1)-1
      default: half_limit = `SSP_LIM_DIV4;
    endcase
  endfunction

  // Divider counter and tick pulse
  always_ff @(posedge clock_in) begin
    if (rst_in || !run_in) begin
      count <= 9'h000;
      tick_out <= 1'b0;
    end else if (mode_in == `SSP_MODE_TMR) begin
      count <= 9'h000;
      tick_out <= timer_tick_in; // Two ticks per bit
    end else if (count >= half_limit(mode_in, reload_in)) begin
      count <= 9'h000;
      tick_out <= 1'b1;
    end else begin
      count <= count + 9'h001;
      tick_out <= 1'b0;
    end
  end
endmodule // ssp_baud_gen
`default_nettype wire

// [design/ssp_shifter.sv]
/*
  Eight-bit full-duplex shift register with bit counter.
  Assumes lead/trail are one-cycle pulses for idle-to-active and back.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ssp_params.svh"
module ssp_shifter (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clear_in,
  input wire logic load_in,
  input wire ssp_pkg::ssp_byte_t load_data_in,
  input wire logic cke_in,
  input wire logic lead_in,
  input wire logic trail_in,
  input wire logic sdi_in,
  output ssp_pkg::ssp_byte_t shift_reg_out,
  output logic sdo_out,
  output logic [2:0] count_out,
  output logic byte_done_out
);
  logic capture;
  logic launch;

  // Capture and launch sit on opposite edges
  assign capture = cke_in ? lead_in : trail_in;
  assign launch = cke_in ? trail_in : lead_in;

  // Shift register: received bit enters the LSb
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      shift_reg_out <= `SSP_RST_BYTE;
    end else if (load_in) begin
      shift_reg_out <= load_data_in;
    end else if (capture) begin
      shift_reg_out <= {shift_reg_out[6:0], sdi_in};
    end
  end

  // Bit counter and end-of-byte pulse
  always_ff @(posedge clock_in) begin
    if (rst_in || clear_in || load_in) begin
      count_out <= 3'h0;
      byte_done_out <= 1'b0;
    end else begin
      byte_done_out <= capture && (count_out == `SSP_LAST_BIT);
      if (capture) begin
        count_out <= count_out + 3'h1;
      end
    end
  end

  // Serial output: MSb first, valid early when cke is set
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sdo_out <= 1'b0;
    end else if (load_in && cke_in) begin
      sdo_out <= load_data_in[7];
    end else if (launch) begin
      sdo_out <= shift_reg_out[7];
    end
  end
endmodule // ssp_shifter
`default_nettype wire

// [design/ssp_spi_port.sv]
/*
  SPI data path of the synchronous serial port, with APB registers,
  master clock generation, slave select handling and receive buffer.
  Assumes pins are synchronous to clock_in; the pad logic combines each
  output with its enable; timer_tick_in is a one-cycle timer pulse.
*/
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "ssp_params.svh"
module ssp_spi_port (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_out,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe_out,
  input wire logic serial_in_pin_in,
  input wire logic slave_select_pin_n_in,
  output logic slave_select_n_out,
  input wire logic timer_tick_in,
  output logic serial_irq_flag_out
);
  // ==========================================================
  // Register state
  logic smp;
  logic cke;
  logic write_collision_flag;
  logic overflow_flag;
  logic enable;
  logic ckp;
  ssp_pkg::ssp_mode_t mode;
  logic boen;
  ssp_pkg::ssp_byte_t serial_data_buffer;
  ssp_pkg::ssp_byte_t serial_baud_reload;
  logic buffer_full_flag;
  logic serial_irq_flag;

  // ==========================================================
  // Internal signals
  ssp_pkg::ssp_mstate_e mstate;
  logic [3:0] edge_count;
  logic sck_prev;
  logic tick;
  logic is_master;
  logic is_slave;
  logic selected;
  logic slave_active;
  logic m_lead;
  logic m_trail;
  logic s_lead;
  logic s_trail;
  logic lead;
  logic trail;
  logic shift_clear;
  logic load;
  logic busy;
  logic collision;
  ssp_pkg::ssp_byte_t shift_reg;
  logic shift_sdo;
  logic [2:0] bit_count;
  logic byte_done;
  logic apb_access;
  logic apb_done;
  logic wr_done;
  logic rd_done;

  // ==========================================================
  // Decoding helpers
  function automatic logic mode_is_master(input ssp_pkg::ssp_mode_t m);
    mode_is_master = (m == `SSP_MODE_DIV4) || (m == `SSP_MODE_DIV16) ||
                     (m == `SSP_MODE_DIV64) || (m == `SSP_MODE_TMR) ||
                     (m == `SSP_MODE_BAUD);
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `SSP_OFS_STATUS) || (a == `SSP_OFS_CTRL1) ||
               (a == `SSP_OFS_CTRL3) || (a == `SSP_OFS_DATA) ||
               (a == `SSP_OFS_BAUD) || (a == `SSP_OFS_FLAG);
  endfunction

  // Read value of one register; unused bits read zero
  function automatic logic [31:0] read_word(input logic [7:0] a);
    read_word = `SSP_RST_WORD;
    case (a)
      `SSP_OFS_STATUS: begin
        read_word[`SSP_STAT_SMP] = smp;
        read_word[`SSP_STAT_CKE] = cke;
        read_word[`SSP_STAT_BF] = buffer_full_flag;
      end
      `SSP_OFS_CTRL1: begin
        read_word[`SSP_C1_WRITE_COLLISION_FLAG] = write_collision_flag;
        read_word[`SSP_C1_OVFL] = overflow_flag;
        read_word[`SSP_C1_EN] = enable;
        read_word[`SSP_C1_CKP] = ckp;
        read_word[`SSP_C1_MODE_HI -: 4] = mode;
      end
      `SSP_OFS_CTRL3: read_word[`SSP_C3_BOEN] = boen;
      `SSP_OFS_DATA: read_word[7:0] = serial_data_buffer;
      `SSP_OFS_BAUD: read_word[7:0] = serial_baud_reload;
      `SSP_OFS_FLAG: read_word[`SSP_FLAG_IRQ] = serial_irq_flag;
      default: read_word = `SSP_RST_WORD;
    endcase
  endfunction

  // ==========================================================
  // Mode and selection decode
  assign is_master = enable && mode_is_master(mode);
  assign is_slave = enable && ((mode == `SSP_MODE_SLV_SS) ||
                               (mode == `SSP_MODE_SLV_NOSS));
  assign selected = (mode == `SSP_MODE_SLV_NOSS) || !slave_select_pin_n_in;
  assign slave_active = is_slave && selected;

  // ==========================================================
  // APB handshake: one wait state, effects at the completing edge
  assign apb_access = psel_in && penable_in;
  assign apb_done = apb_access && pready_out;
  assign wr_done = apb_done && pwrite_in;
  assign rd_done = apb_done && !pwrite_in;

  // Ready, read data and error answer
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      prdata_out <= `SSP_RST_WORD;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= apb_access && !pready_out;
      pslverr_out <= apb_access && !pready_out && !addr_hit(paddr_in);
      if (apb_access && !pready_out && !pwrite_in) begin
        prdata_out <= read_word(paddr_in);
      end else begin
        prdata_out <= `SSP_RST_WORD;
      end
    end
  end

  // ==========================================================
  // Buffer write acceptance
  assign busy = (mstate == ssp_pkg::SSP_M_RUN) || (bit_count != 3'h0) || byte_done;
  assign collision = wr_done && (paddr_in == `SSP_OFS_DATA) && busy;
  assign load = wr_done && (paddr_in == `SSP_OFS_DATA) && !busy;
  assign shift_clear = !enable ||
                       ((mode == `SSP_MODE_SLV_SS) && slave_select_pin_n_in);

  // Configuration registers written by software
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      smp <= 1'b0;
      cke <= 1'b0;
      enable <= 1'b0;
      ckp <= 1'b0;
      mode <= `SSP_MODE_DIV4;
      boen <= 1'b0;
      serial_baud_reload <= `SSP_RST_BYTE;
    end else if (wr_done) begin
      case (paddr_in)
        `SSP_OFS_STATUS: begin
          smp <= pwdata_in[`SSP_STAT_SMP]; // Only the upper two bits
          cke <= pwdata_in[`SSP_STAT_CKE];
        end
        `SSP_OFS_CTRL1: begin
          enable <= pwdata_in[`SSP_C1_EN];
          ckp <= pwdata_in[`SSP_C1_CKP];
          mode <= pwdata_in[`SSP_C1_MODE_HI -: 4];
        end
        `SSP_OFS_CTRL3: boen <= pwdata_in[`SSP_C3_BOEN];
        `SSP_OFS_BAUD: serial_baud_reload <= pwdata_in[7:0];
        default: ;
      endcase
    end
  end

  // Collision and overflow flags; hardware set wins over clear
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      write_collision_flag <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      if (collision) begin
        write_collision_flag <= 1'b1;
      end else if (wr_done && (paddr_in == `SSP_OFS_CTRL1)) begin
        write_collision_flag <= pwdata_in[`SSP_C1_WRITE_COLLISION_FLAG];
      end
      if (byte_done && buffer_full_flag && !boen) begin
        overflow_flag <= 1'b1;
      end else if (wr_done && (paddr_in == `SSP_OFS_CTRL1)) begin
        overflow_flag <= pwdata_in[`SSP_C1_OVFL];
      end
    end
  end

  // Data buffer: written by software or by a received byte
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      serial_data_buffer <= `SSP_RST_BYTE;
    end else if (byte_done && (!buffer_full_flag || boen)) begin
      serial_data_buffer <= shift_reg;
    end else if (load) begin
      serial_data_buffer <= pwdata_in[7:0];
    end
  end

  // Buffer full: set on receive, cleared by a buffer read
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      buffer_full_flag <= 1'b0;
    end else if (byte_done) begin
      buffer_full_flag <= 1'b1;
    end else if (rd_done && (paddr_in == `SSP_OFS_DATA)) begin
      buffer_full_flag <= 1'b0;
    end
  end

  // Serial interrupt flag, write one to clear
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      serial_irq_flag <= 1'b0;
      serial_irq_flag_out <= 1'b0;
    end else begin
      serial_irq_flag_out <= serial_irq_flag;
      if (byte_done) begin
        serial_irq_flag <= 1'b1;
      end else if (wr_done && (paddr_in == `SSP_OFS_FLAG) &&
                   pwdata_in[`SSP_FLAG_IRQ]) begin
        serial_irq_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Master clock generation
  ssp_baud_gen u_baud (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .run_in(mstate == ssp_pkg::SSP_M_RUN),
    .mode_in(mode),
    .reload_in(serial_baud_reload),
    .timer_tick_in(timer_tick_in),
    .tick_out(tick)
  );

  // Edge pulses of our own clock, relative to the idle level
  assign m_lead = (mstate == ssp_pkg::SSP_M_RUN) && tick && (serial_clock_pin_out == ckp);
  assign m_trail = (mstate == ssp_pkg::SSP_M_RUN) && tick && (serial_clock_pin_out != ckp);

  // Master sequencer: sixteen half periods per byte
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mstate <= ssp_pkg::SSP_M_IDLE;
      edge_count <= 4'h0;
      serial_clock_pin_out <= 1'b0;
      slave_select_n_out <= 1'b1;
    end else if (!is_master) begin
      mstate <= ssp_pkg::SSP_M_IDLE;
      edge_count <= 4'h0;
      serial_clock_pin_out <= ckp;
      slave_select_n_out <= 1'b1;
    end else begin
      unique case (mstate)
        ssp_pkg::SSP_M_IDLE: begin
          serial_clock_pin_out <= ckp; // Idle level
          edge_count <= 4'h0;
          if (load) begin
            mstate <= ssp_pkg::SSP_M_RUN; // Write starts the exchange
            slave_select_n_out <= 1'b0;
          end
        end
        ssp_pkg::SSP_M_RUN: begin
          if (tick) begin
            serial_clock_pin_out <= !serial_clock_pin_out;
            edge_count <= edge_count + 4'h1;
            if (edge_count == `SSP_LAST_EDGE) begin
              mstate <= ssp_pkg::SSP_M_IDLE; // Clock stops
              slave_select_n_out <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Slave clock edge detection on the sampled pin
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= serial_clock_pin_in;
    end
  end

  assign s_lead = slave_active && (sck_prev == ckp) && (serial_clock_pin_in != ckp);
  assign s_trail = slave_active && (sck_prev != ckp) && (serial_clock_pin_in == ckp);
  assign lead = is_master ? m_lead : s_lead;
  assign trail = is_master ? m_trail : s_trail;

  // ==========================================================
  // Shift register and bit counter
  ssp_shifter u_shift (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .clear_in(shift_clear),
    .load_in(load),
    .load_data_in(pwdata_in[7:0]),
    .cke_in(cke),
    .lead_in(lead),
    .trail_in(trail),
    .sdi_in(serial_in_pin_in), // Partner's output enters here
    .shift_reg_out(shift_reg),
    .sdo_out(shift_sdo),
    .count_out(bit_count),
    .byte_done_out(byte_done)
  );

  // ==========================================================
  // Pin drivers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      serial_clock_pin_oe_out <= 1'b0;
      serial_out_pin_oe_out <= 1'b0;
      serial_out_pin_out <= 1'b0;
    end else begin
      serial_clock_pin_oe_out <= is_master; // Slave never drives clock
      serial_out_pin_oe_out <= is_master || slave_active;
      serial_out_pin_out <= shift_sdo; // To partner's input
    end
  end
endmodule // ssp_spi_port
`default_nettype wire

// [tb/ssp_spi_props.sv]
/*
  Checker of the SPI port's APB answer and master serial pins.
  Assumes binding to ssp_spi_port and a clock idle level of 0.
*/
`timescale 1ns/100ps
`default_nettype none
module ssp_spi_props (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe_out,
  input wire logic serial_out_pin_oe_out,
  input wire logic slave_select_n_out
);
  logic [4:0] edge_cnt;
  logic clk_q;
  // ==========================================================
  // Clock toggles seen while select is low
  always_ff @(posedge clock_in) begin
    clk_q <= serial_clock_pin_out;
    if (rst_in || slave_select_n_out) begin
      edge_cnt <= 5'h00;
    end else if (serial_clock_pin_out != clk_q) begin
      edge_cnt <= edge_cnt + 5'h01;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // ==========================================================
  // Properties
  ready_one_cycle_a: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  ready_in_access_a: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready outside access");
  ready_wait_one_a: assert property ($rose(penable_in) |=> pready_out)
    else $error("ready not after one wait");
  err_with_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  rdata_idle_zero_a: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data outside answer");
  clock_when_sel_a: assert property ($changed(serial_clock_pin_out) |->
    !$past(slave_select_n_out)) else $error("clock outside byte");
  byte_edges_a: assert property ($rose(slave_select_n_out) |->
    edge_cnt == 5'h0F && $changed(serial_clock_pin_out))
    else $error("byte not sixteen edges");
  sel_holds_a: assert property ($fell(slave_select_n_out) |-> !slave_select_n_out [*8])
    else $error("select dropped early");
  master_drives_a: assert property (serial_clock_pin_oe_out |-> serial_out_pin_oe_out)
    else $error("master output not driven");
  cover property ($fell(slave_select_n_out));
  cover property (pslverr_out);
  cover property ($rose(slave_select_n_out));
endmodule // ssp_spi_props
bind ssp_spi_port ssp_spi_props i_props (.clock_in, .rst_in, .psel_in, .penable_in,
  .prdata_out, .pready_out, .pslverr_out, .serial_clock_pin_out,
  .serial_clock_pin_oe_out, .serial_out_pin_oe_out, .slave_select_n_out);
`default_nettype wire

// [tb/ssp_slave_model.sv]
/*
  Behavioural SPI slave, clock idle low, capture on leading edge.
  Assumes its clock, select and data come from the port in master mode.
*/
`timescale 1ns/100ps
`default_nettype none
module ssp_slave_model (
  input wire logic clock_in,
  input wire logic sclk_in,
  input wire logic sel_n_in, // One slave, one select
  input wire logic mosi_in,
  input wire ssp_pkg::ssp_byte_t tx_in,
  output logic miso_out,
  output ssp_pkg::ssp_byte_t got_out
);
  logic sclk_q = 1'b0;
  logic sel_q = 1'b1;
  logic bit_in = 1'b0;
  logic last = 1'b0;
  ssp_pkg::ssp_byte_t sr = 8'h00;
  // Load on select, capture on rise, shift on fall
  always_ff @(posedge clock_in) begin
    sclk_q <= sclk_in;
    sel_q <= sel_n_in;
    if (sel_q && !sel_n_in) begin
      sr <= tx_in;
    end else if (!sel_n_in && sclk_in && !sclk_q) begin
      bit_in <= mosi_in;
    end else if (!sel_q && !sclk_in && sclk_q) begin // Delayed select keeps the last fall
      sr <= {sr[6:0], bit_in};
    end
    if (!sel_n_in) begin
      last <= miso_out;
    end
  end
  // Released line shows the inverse of the last bit
  assign miso_out = sel_n_in ? ~last : sr[7];
  assign got_out = sr;
endmodule // ssp_slave_model
`default_nettype wire

// [tb/tb_sync_serial_spi_port.sv]
/*
  Self-checking bench of the SPI port: master rows, then hand tests.
  Assumes the slave model and checker files are compiled with it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ssp_params.svh"
module tb_sync_serial_spi_port;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, sclk_o, sclk_oe, sdo, sdo_oe, sel_n, irq, miso;
  logic tb_sclk = 1'b0, tb_sdi = 1'b0, tb_ss_n = 1'b1, slave_on = 1'b0, tick = 1'b0;
  logic sclk_prev = 1'b0;
  ssp_pkg::ssp_byte_t m_tx = 8'h00, got;
  int fails = 0, checks = 0, cyc = 0, tgl = 0, t1 = 0, t2 = 0;
  typedef struct {
    ssp_pkg::ssp_mode_t mode;
    ssp_pkg::ssp_byte_t reload, tx, rx;
    int half;
  } ssp_row_s;
  ssp_row_s rows [5] = '{'{4'h0, 8'h00, 8'hA5, 8'h3C, 2}, '{4'h1, 8'h00, 8'h81, 8'h7E, 8},
    '{4'h2, 8'h00, 8'h01, 8'h80, 32}, '{4'hA, 8'h03, 8'hFF, 8'h00, 8},
    '{4'h3, 8'h00, 8'h5A, 8'hC3, 4}};
  always #20 clock_in = ~clock_in;
  ssp_spi_port i_dut (.clock_in, .rst_in, .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .serial_clock_pin_in(tb_sclk),
    .serial_clock_pin_out(sclk_o), .serial_clock_pin_oe_out(sclk_oe),
    .serial_out_pin_out(sdo), .serial_out_pin_oe_out(sdo_oe),
    .serial_in_pin_in(slave_on ? tb_sdi : miso), .slave_select_pin_n_in(tb_ss_n),
    .slave_select_n_out(sel_n), .timer_tick_in(tick), .serial_irq_flag_out(irq));
  ssp_slave_model i_slave (.clock_in, .sclk_in(sclk_o), .sel_n_in(sel_n),
    .mosi_in(sdo), .tx_in(m_tx), .miso_out(miso), .got_out(got));
  // ==========================================================
  // Timer tick, toggle timing and timeout
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    tick <= (cyc % 4) == 3;
    sclk_prev <= sclk_o;
    if (sclk_o !== sclk_prev) begin
      tgl <= tgl + 1;
      if (tgl == 1) t1 <= cyc;
      if (tgl == 2) t2 <= cyc;
    end
    if (cyc == 40000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    checks++;
    if (got_v !== exp_v) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1) @(posedge clock_in);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wait_irq;
    rd = 32'h0;
    for (int i = 0; i < 300 && rd[0] !== 1'b1; i++) apb(1'b0, `SSP_OFS_FLAG, 32'h0);
    // Let the last clock toggle and the partner's last shift settle
    for (int i = 0; i < 300 && sel_n !== 1'b1; i++) @(posedge clock_in);
    repeat (2) @(posedge clock_in);
  endtask
  task automatic pulse(input logic b);
    @(posedge clock_in);
    tb_sdi <= b;
    repeat (3) @(posedge clock_in);
    tb_sclk <= 1'b1;
    repeat (4) @(posedge clock_in);
    tb_sclk <= 1'b0;
    repeat (3) @(posedge clock_in);
  endtask
  task report_and_stop;
    if (fails == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    chk(sel_n, 1'b1);
    rd_chk(`SSP_OFS_STATUS, 32'h0);
    rd_chk(`SSP_OFS_CTRL1, 32'h0);
    apb(1'b1, `SSP_OFS_STATUS, 32'hFFFF_FFFF);
    rd_chk(`SSP_OFS_STATUS, 32'h0000_00C0);
    apb(1'b1, `SSP_OFS_STATUS, 32'h0000_0040);
    rd_chk(8'h18, 32'h0);
    chk(err, 1'b1);
    // Master rows over every clock source
    foreach (rows[i]) begin
      apb(1'b1, `SSP_OFS_BAUD, {24'h0, rows[i].reload});
      apb(1'b1, `SSP_OFS_CTRL1, {24'h0, 4'h2, rows[i].mode});
      m_tx = rows[i].rx;
      tgl = 0;
      apb(1'b1, `SSP_OFS_DATA, {24'h0, rows[i].tx});
      wait_irq();
      chk(tgl, 16);
      chk(t2 - t1, rows[i].half);
      chk(got, rows[i].tx);
      chk(irq, 1'b1);
      chk(sclk_oe, 1'b1);
      rd_chk(`SSP_OFS_STATUS, 32'h0000_0041);
      rd_chk(`SSP_OFS_DATA, {24'h0, rows[i].rx});
      rd_chk(`SSP_OFS_STATUS, 32'h0000_0040);
      apb(1'b1, `SSP_OFS_FLAG, 32'h1);
    end
    // Write during a byte is dropped and flagged
    apb(1'b1, `SSP_OFS_CTRL1, 32'h22);
    m_tx = 8'h66;
    apb(1'b1, `SSP_OFS_DATA, 32'h99);
    apb(1'b1, `SSP_OFS_DATA, 32'h11);
    rd_chk(`SSP_OFS_CTRL1, 32'hA2);
    wait_irq();
    chk(got, 8'h99);
    rd_chk(`SSP_OFS_DATA, 32'h66);
    apb(1'b1, `SSP_OFS_CTRL1, 32'h22);
    rd_chk(`SSP_OFS_CTRL1, 32'h22);
    apb(1'b1, `SSP_OFS_FLAG, 32'h1);
    // Slave with select: unselected pulses are ignored
    apb(1'b1, `SSP_OFS_CTRL1, 32'h24);
    slave_on <= 1'b1;
    repeat (3) pulse(1'b1);
    chk(sdo_oe, 1'b0);
    chk(sclk_oe, 1'b0);
    apb(1'b1, `SSP_OFS_DATA, {24'h0, rows[0].rx});
    tb_ss_n <= 1'b0;
    repeat (4) @(posedge clock_in);
    chk(sdo_oe, 1'b1);
    for (int i = 7; i >= 0; i--) begin
      chk(sdo, rows[0].rx[i]);
      pulse(rows[0].tx[i]);
    end
    tb_ss_n <= 1'b1;
    repeat (4) @(posedge clock_in);
    chk(sdo_oe, 1'b0);
    wait_irq();
    // Second byte while the buffer is full: old byte kept, overflow set
    tb_ss_n <= 1'b0;
    repeat (8) pulse(1'b0);
    rd_chk(`SSP_OFS_CTRL1, 32'h64);
    rd_chk(`SSP_OFS_DATA, 32'hA5);
    // Slave ignoring select drives its output while enabled
    apb(1'b1, `SSP_OFS_CTRL1, 32'h25);
    tb_ss_n <= 1'b1;
    repeat (2) @(posedge clock_in);
    chk(sdo_oe, 1'b1);
    report_and_stop();
  end
endmodule // tb_sync_serial_spi_port
`default_nettype wire
